/* File: hdl/eisw_top.sv */
// Purpose: external edge interrupt, flag and enables, sleep and wake sequencing
// Assumes: core pulses core_sleep on a sleep instruction and core_instr_done per instruction
// Notes:   core clock is gated here through core_clk_en; ref_clk itself keeps running
//
// Local design decisions: the register addresses and the strobed register port.

`timescale 1ns/100ps
`default_nettype none

module eisw_top
	import eisw_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            ext_pin,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [7:0]      reg_rdata,
	input  wire logic            core_sleep,
	input  wire logic            core_instr_done,
	output logic                 core_clk_en,
	output logic                 branch_req,
	output logic      [PC_W-1:0] branch_pc,
	output logic                 push_return,
	output logic                 irq
);

	logic                 global_irq_enable;
	logic                 ext_irq_enable;
	logic                 ext_irq_flag;
	logic                 ext_edge_select;
	logic [EVT_W-1:0]     evt_status;
	logic [EVT_W-1:0]     evt_mask;
	logic [EVT_W-1:0]     evt_set;
	eisw_state_type       state;
	eisw_state_type       next_state;
	logic                 edge_pulse;
	logic                 pin_level;
	logic                 wr_control;
	logic                 wr_option;
	logic                 wr_status;
	logic                 wr_mask;
	logic                 irq_cond;
	logic                 wake_cond;
	logic                 take_branch;
	logic                 wake_event;

	// -------------------------------------------------------------------
	// edge capture
	// -------------------------------------------------------------------
	eisw_edge_capture u_eisw_edge_capture (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.ext_pin         (ext_pin),
		.ext_edge_select (ext_edge_select),
		.edge_pulse      (edge_pulse),
		.pin_level       (pin_level)
	);

	// -------------------------------------------------------------------
	// write decode
	// -------------------------------------------------------------------
	always_comb begin
		wr_control = 1'b0;
		wr_option  = 1'b0;
		wr_status  = 1'b0;
		wr_mask    = 1'b0;
		if (reg_wr && reg_addr == ADDR_IRQ_CONTROL) begin
			wr_control = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_OPTION) begin
			wr_option = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_EVT_STATUS) begin
			wr_status = 1'b1;
		end else if (reg_wr && reg_addr == ADDR_EVT_MASK) begin
			wr_mask = 1'b1;
		end
	end

	// -------------------------------------------------------------------
	// interrupt conditions
	// -------------------------------------------------------------------
	assign irq_cond  = ext_irq_flag && ext_irq_enable && global_irq_enable;
	// wake needs the flag and ext_irq_enable, which may be set during sleep; global enable not needed
	assign wake_cond = ext_irq_flag && ext_irq_enable;

	// in run mode, or in step once the instruction is done; one pulse only, global enable drops with it
	always_comb begin
		take_branch = 1'b0;
		if (state == ST_RUN && irq_cond && !branch_req) begin
			take_branch = 1'b1;
		end else if (state == ST_STEP && core_instr_done && irq_cond) begin
			take_branch = 1'b1;
		end
	end

	// -------------------------------------------------------------------
	// control and option register fields
	// -------------------------------------------------------------------
	// set by the edge whatever the enables; no clear on entry or exit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_irq_flag <= 1'b0;
		end else if (edge_pulse) begin
			ext_irq_flag <= 1'b1;
		end else if (wr_control) begin
			ext_irq_flag <= reg_wdata[BIT_EXT_IRQ_FLAG];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_irq_enable <= 1'b0;
		end else if (wr_control) begin
			ext_irq_enable <= reg_wdata[BIT_EXT_IRQ_ENABLE];
		end
	end

	// entry drops the global enable so the same flag cannot re-enter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
		end else if (wr_control) begin
			global_irq_enable <= reg_wdata[BIT_GLOBAL_IRQ_ENABLE];
		end else if (take_branch) begin
			global_irq_enable <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_edge_select <= RST_EXT_EDGE_SELECT;
		end else if (wr_option) begin
			ext_edge_select <= reg_wdata[BIT_EXT_EDGE_SELECT];
		end
	end

	// -------------------------------------------------------------------
	// sleep and wake sequencing
	// -------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (core_sleep && !branch_req) begin
					next_state = wake_cond ? ST_STEP : ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_cond) begin
					next_state = ST_STEP;
				end
			end
			ST_STEP: begin
				if (core_instr_done) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign wake_event = (state == ST_SLEEP) && (next_state == ST_STEP);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_clk_en <= 1'b1;
		end else begin
			core_clk_en <= (next_state != ST_SLEEP);
		end
	end

	// -------------------------------------------------------------------
	// branch to the vector
	// -------------------------------------------------------------------
	// only the return address push is requested; no upper latch write exists
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			branch_req  <= 1'b0;
			push_return <= 1'b0;
		end else begin
			branch_req  <= take_branch;
			push_return <= take_branch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			branch_pc <= VECTOR_ADDR;
		end else begin
			branch_pc <= VECTOR_ADDR;
		end
	end

	// -------------------------------------------------------------------
	// event status, mask and interrupt line
	// -------------------------------------------------------------------
	always_comb begin
		evt_set                 = '0;
		evt_set[BIT_EVT_EDGE]   = edge_pulse;
		evt_set[BIT_EVT_WAKE]   = wake_event;
		evt_set[BIT_EVT_BRANCH] = take_branch;
	end

	// set wins over a same-cycle write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			evt_status <= '0;
		end else if (wr_status) begin
			evt_status <= (evt_status & ~reg_wdata[EVT_W-1:0]) | evt_set;
		end else begin
			evt_status <= evt_status | evt_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			evt_mask <= RST_EVT_MASK;
		end else if (wr_mask) begin
			evt_mask <= reg_wdata[EVT_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_status & evt_mask);
		end
	end

	// -------------------------------------------------------------------
	// read port
	// -------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == ADDR_IRQ_CONTROL) begin
			reg_rdata                        <= 8'h00;
			reg_rdata[BIT_GLOBAL_IRQ_ENABLE] <= global_irq_enable;
			reg_rdata[BIT_EXT_IRQ_ENABLE]    <= ext_irq_enable;
			reg_rdata[BIT_EXT_IRQ_FLAG]      <= ext_irq_flag;
		end else if (reg_addr == ADDR_OPTION) begin
			reg_rdata                      <= 8'h00;
			reg_rdata[BIT_EXT_EDGE_SELECT] <= ext_edge_select;
		end else if (reg_addr == ADDR_EVT_STATUS) begin
			reg_rdata <= {5'h00, evt_status};
		end else if (reg_addr == ADDR_EVT_MASK) begin
			reg_rdata <= {5'h00, evt_mask};
		end else if (reg_addr == ADDR_STATE) begin
			reg_rdata <= {5'h00, pin_level, state};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	property p_flag_set;
		@(posedge ref_clk) disable iff (rst)
		edge_pulse |=> ext_irq_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by edge");

	property p_flag_regardless;
		@(posedge ref_clk) disable iff (rst)
		(edge_pulse && !ext_irq_enable && !global_irq_enable) |=> ext_irq_flag;
	endproperty
	a_flag_regardless: assert property (p_flag_regardless) else $error("flag gated by enable");

	property p_flag_kept;
		@(posedge ref_clk) disable iff (rst)
		(ext_irq_flag && !wr_control) |=> ext_irq_flag;
	endproperty
	a_flag_kept: assert property (p_flag_kept) else $error("flag cleared by hardware");

	property p_branch_cause;
		@(posedge ref_clk) disable iff (rst)
		branch_req |-> $past(ext_irq_flag && ext_irq_enable && global_irq_enable);
	endproperty
	a_branch_cause: assert property (p_branch_cause) else $error("branch without cause");

	property p_run_branch;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_RUN && irq_cond && !branch_req) |=> branch_req && !global_irq_enable;
	endproperty
	a_run_branch: assert property (p_run_branch) else $error("pending request not taken");

	property p_vector;
		@(posedge ref_clk) disable iff (rst)
		branch_req |-> branch_pc == 13'h0004;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector address");

	property p_push_pair;
		@(posedge ref_clk) disable iff (rst)
		branch_req == push_return;
	endproperty
	a_push_pair: assert property (p_push_pair) else $error("push not paired with branch");

	property p_sleep_hold;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_SLEEP && !ext_irq_enable) |=> state == ST_SLEEP && !core_clk_en;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("woke without enable");

	property p_wake;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_SLEEP && ext_irq_flag && ext_irq_enable) |=> state == ST_STEP ##0 core_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("enabled flag did not wake core");

	property p_step_first;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_STEP && !core_instr_done) |=> !branch_req;
	endproperty
	a_step_first: assert property (p_step_first) else $error("branch before next instruction");

	property p_wake_resume;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_STEP && core_instr_done && !global_irq_enable)
			|=> state == ST_RUN && !branch_req;
	endproperty
	a_wake_resume: assert property (p_wake_resume) else $error("branch with global off");

	property p_wake_branch;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_STEP && core_instr_done && irq_cond) |=> branch_req;
	endproperty
	a_wake_branch: assert property (p_wake_branch) else $error("no branch after wake");

	c_branch_run: cover property (@(posedge ref_clk) disable iff (rst)
		state == ST_RUN ##1 branch_req);
	c_wake_branch: cover property (@(posedge ref_clk) disable iff (rst)
		state == ST_SLEEP ##1 state == ST_STEP ##[1:20] branch_req);
	c_wake_resume: cover property (@(posedge ref_clk) disable iff (rst)
		state == ST_STEP && core_instr_done && !global_irq_enable);
	c_falling_edge: cover property (@(posedge ref_clk) disable iff (rst)
		edge_pulse && !ext_edge_select);

endmodule

`default_nettype wire

/* File: hdl/eisw_pkg.sv */
// Purpose: constants and types shared by the external interrupt and sleep wake logic
// Assumes: 8-bit register port, one core clock, pin edges captured without the clock
// Notes:   register map, field positions and the edge select and event mask reset values live here only

package eisw_pkg;

	// -------------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_OPTION      = 8'h01;
	localparam logic [7:0] ADDR_EVT_STATUS  = 8'h02;
	localparam logic [7:0] ADDR_EVT_MASK    = 8'h03;
	localparam logic [7:0] ADDR_STATE       = 8'h04;

	// -------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------
	localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
	localparam int BIT_EXT_IRQ_ENABLE    = 4;
	localparam int BIT_EXT_IRQ_FLAG      = 1;
	localparam int BIT_EXT_EDGE_SELECT   = 6;
	localparam int BIT_EVT_EDGE          = 0;
	localparam int BIT_EVT_WAKE          = 1;
	localparam int BIT_EVT_BRANCH        = 2;
	localparam int EVT_W                 = 3;

	// -------------------------------------------------------------------
	// reset values and program counter figures
	// -------------------------------------------------------------------
	localparam logic       RST_EXT_EDGE_SELECT = 1'h1;
	localparam logic [2:0] RST_EVT_MASK        = 3'h0;
	localparam int         PC_W                = 13;
	localparam logic [12:0] VECTOR_ADDR        = 13'h0004;

	// -------------------------------------------------------------------
	// sleep and wake sequencing
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN   = 2'h0,
		ST_SLEEP = 2'h1,
		ST_STEP  = 2'h3
	} eisw_state_type;

endpackage

/* File: hdl/eisw_edge_capture.sv */
// Purpose: clockless edge capture of the external pin and transfer into ref_clk
// Assumes: ext_pin is asynchronous; edge select is quasi-static
// Notes:   capture flop is clocked by the pin itself, so it works with clocks stopped

`timescale 1ns/100ps
`default_nettype none

module eisw_edge_capture (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ext_pin,
	input  wire logic ext_edge_select,
	output logic      edge_pulse,
	output logic      pin_level
);

	logic trigger;
	logic capture_toggle;
	logic toggle_meta;
	logic toggle_sync;
	logic toggle_seen;
	logic pin_meta;

	// -------------------------------------------------------------------
	// pin-clocked capture
	// -------------------------------------------------------------------
	assign trigger = ext_edge_select ? ext_pin : ~ext_pin;

	// edge, not level: one toggle per active edge, no core clock needed
	always_ff @(posedge trigger or posedge rst) begin
		if (rst) begin
			capture_toggle <= 1'b0;
		end else begin
			capture_toggle <= ~capture_toggle;
		end
	end

	// -------------------------------------------------------------------
	// crossing into ref_clk
	// -------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			toggle_meta <= 1'b0;
			toggle_sync <= 1'b0;
			toggle_seen <= 1'b0;
			edge_pulse  <= 1'b0;
		end else begin
			toggle_meta <= capture_toggle;
			toggle_sync <= toggle_meta;
			toggle_seen <= toggle_sync;
			edge_pulse  <= toggle_sync ^ toggle_seen;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_meta  <= 1'b0;
			pin_level <= 1'b0;
		end else begin
			pin_meta  <= ext_pin;
			pin_level <= pin_meta;
		end
	end

endmodule

`default_nettype wire

/* File: test/eisw_core_model.sv */
// Purpose: core stand-in issuing sleep and the first instruction after wake
// Assumes: the core only advances while core_clk_en is high
// Notes:   step_delay sets how slowly that instruction completes

`timescale 1ns/100ps
`default_nettype none

module eisw_core_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       sleep_cmd,
	input  wire logic [3:0] step_delay,
	input  wire logic       core_clk_en,
	output logic            core_sleep,
	output logic            core_instr_done
);
	logic       waiting;
	logic [3:0] cnt;

	// -------------------------------------------------------------------
	// sleep, then one instruction once the clock runs again
	// -------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_sleep      <= 1'h0;
			core_instr_done <= 1'h0;
			waiting         <= 1'h0;
			cnt             <= 4'h0;
		end else begin
			core_sleep      <= sleep_cmd;
			core_instr_done <= 1'h0;
			if (sleep_cmd) begin
				waiting <= 1'h1;
				cnt     <= step_delay;
			end else if (waiting && core_clk_en && !core_sleep) begin
				// gated clock: no progress while core_clk_en is low
				if (cnt == 4'h0) begin
					core_instr_done <= 1'h1;
					waiting         <= 1'h0;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* File: test/eisw_bench.sv */
// Purpose: self-checking bench for the edge interrupt and sleep wake block
// Assumes: register port with read data one cycle after the strobe
// Notes:   the bench itself plays the external pin source

`timescale 1ns/100ps
`default_nettype none

module eisw_bench
	import eisw_pkg::*;
;
	logic            ref_clk;
	logic            rst;
	logic            ext_pin;
	logic            reg_wr;
	logic            reg_rd;
	logic            sleep_cmd;
	logic [7:0]      reg_addr;
	logic [7:0]      reg_wdata;
	logic [7:0]      reg_rdata;
	logic [3:0]      step_delay;
	logic            core_sleep;
	logic            core_instr_done;
	logic            core_clk_en;
	logic            branch_req;
	logic            push_return;
	logic            irq;
	logic [PC_W-1:0] branch_pc;
	int              n_errors;
	int              n_tests;
	int              done_cnt = 0;
	int              done_at_branch;
	int              k;

	eisw_top u_eisw_top (
		.ref_clk(ref_clk), .rst(rst), .ext_pin(ext_pin), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.core_sleep(core_sleep), .core_instr_done(core_instr_done),
		.core_clk_en(core_clk_en), .branch_req(branch_req), .branch_pc(branch_pc),
		.push_return(push_return), .irq(irq)
	);

	eisw_core_model u_eisw_core_model (
		.ref_clk(ref_clk), .rst(rst), .sleep_cmd(sleep_cmd), .step_delay(step_delay),
		.core_clk_en(core_clk_en), .core_sleep(core_sleep), .core_instr_done(core_instr_done)
	);

	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (core_instr_done === 1'h1)
			done_cnt <= done_cnt + 1;
	end

	// -------------------------------------------------------------------
	// access and check tasks
	// -------------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		chk(16'(reg_rdata), 16'(e));
	endtask

	task automatic pin(input logic v);
		@(posedge ref_clk);
		ext_pin <= v;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic wait_branch(input logic exp);
		logic got;
		got = 1'h0;
		for (int i = 0; i < 24 && !got; i++) begin
			@(negedge ref_clk);
			got = (branch_req === 1'h1);
		end
		chk(16'(got), 16'(exp));
		if (got) begin
			done_at_branch = done_cnt;
			chk(16'(branch_pc), 16'(VECTOR_ADDR));
			chk(16'(push_return), 16'h0001);
			@(negedge ref_clk);
			chk(16'(branch_req), 16'h0000);
		end
		if (exp && !got)
			test_done();
	endtask

	task automatic wait_wake();
		for (int i = 0; i < 24 && core_clk_en !== 1'h1; i++)
			@(negedge ref_clk);
		chk(16'(core_clk_en), 16'h0001);
		if (core_clk_en !== 1'h1)
			test_done();
	endtask

	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		// nba so the pin-clocked flop sees the reset edge at time zero
		rst <= 1'h1;
		ext_pin = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		sleep_cmd = 1'h0;
		step_delay = 4'h0;
		n_errors = 0;
		n_tests = 0;
		done_at_branch = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (4) @(negedge ref_clk);
		chk(16'(core_clk_en), 16'h0001);
		chk(16'(branch_pc), 16'(VECTOR_ADDR));
		rd(ADDR_IRQ_CONTROL, 8'h00);
		rd(ADDR_OPTION, 8'h40);
		rd(ADDR_EVT_MASK, 8'h00);
		rd(ADDR_STATE, 8'h00);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h00);
		rd(ADDR_IRQ_CONTROL, 8'h00);
		$display("test reset values done");

		// both polarities, all enables off
		for (int s = 1; s >= 0; s--) begin
			wr(ADDR_OPTION, s[0] ? 8'h40 : 8'h00);
			repeat (8) @(posedge ref_clk);
			wr(ADDR_IRQ_CONTROL, 8'h00);
			pin(1'h1);
			rd(ADDR_IRQ_CONTROL, s[0] ? 8'h02 : 8'h00);
			rd(ADDR_STATE, 8'h04);
			wr(ADDR_IRQ_CONTROL, 8'h00);
			pin(1'h0);
			rd(ADDR_IRQ_CONTROL, s[0] ? 8'h00 : 8'h02);
		end
		rd(ADDR_EVT_STATUS, 8'h01);
		chk(16'(irq), 16'h0000);
		$display("test edge polarity done");

		wr(ADDR_OPTION, 8'h40);
		repeat (8) @(posedge ref_clk);
		wr(ADDR_EVT_STATUS, 8'h07);
		wr(ADDR_EVT_MASK, 8'h04);
		wr(ADDR_IRQ_CONTROL, 8'h90);
		@(posedge ref_clk);
		ext_pin <= 1'h1;
		wait_branch(1'h1);
		rd(ADDR_IRQ_CONTROL, 8'h12);
		chk(16'(irq), 16'h0001);
		wr(ADDR_EVT_STATUS, 8'h04);
		repeat (2) @(negedge ref_clk);
		chk(16'(irq), 16'h0000);
		rd(ADDR_EVT_STATUS, 8'h01);
		$display("test running interrupt done");

		wr(ADDR_IRQ_CONTROL, 8'h80);
		step_delay <= 4'h5;
		sleep_cmd <= 1'h1;
		@(posedge ref_clk);
		sleep_cmd <= 1'h0;
		pin(1'h0);
		pin(1'h1);
		chk(16'(core_clk_en), 16'h0000);
		wait_branch(1'h0);
		rd(ADDR_IRQ_CONTROL, 8'h82);
		rd(ADDR_STATE, 8'h05);
		k = done_cnt;
		wr(ADDR_IRQ_CONTROL, 8'h92);
		wait_wake();
		wait_branch(1'h1);
		chk(16'(done_at_branch - k), 16'h0001);
		$display("test enable blocks wake done");

		wr(ADDR_IRQ_CONTROL, 8'h10);
		wr(ADDR_EVT_STATUS, 8'h07);
		step_delay <= 4'h0;
		sleep_cmd <= 1'h1;
		@(posedge ref_clk);
		sleep_cmd <= 1'h0;
		pin(1'h0);
		chk(16'(core_clk_en), 16'h0000);
		@(posedge ref_clk);
		ext_pin <= 1'h1;
		wait_wake();
		wait_branch(1'h0);
		rd(ADDR_EVT_STATUS, 8'h03);
		rd(ADDR_STATE, 8'h04);
		$display("test wake and resume done");

		// flag and enable already set: sleep acts as a no-op step
		k = done_cnt;
		@(posedge ref_clk);
		sleep_cmd <= 1'h1;
		@(posedge ref_clk);
		sleep_cmd <= 1'h0;
		repeat (4) @(negedge ref_clk);
		chk(16'(core_clk_en), 16'h0001);
		chk(16'(done_cnt - k), 16'h0001);
		rd(ADDR_STATE, 8'h04);
		rd(ADDR_EVT_STATUS, 8'h03);
		$display("test sleep with pending wake done");
		test_done();
	end
endmodule

`default_nettype wire
